// ### ctrl_port_pkg.sv
// Purpose: Shared constants for the serial control port and its host.
// Assumes: 20 MHz system clock on both ends.
// Notes: Instruction byte fields and register addresses live here.
package ctrl_port_pkg;
	// Latch pin count
	localparam int LATCH_W = 6;
	// Index of the last bit in one control byte
	localparam logic [3:0] BYTE_LAST = 4'h7;
	// Instruction byte fields
	localparam int P_BIT = 7;
	localparam int ADDR_HI = 6;
	localparam int ADDR_LO = 3;
	localparam int RW_BIT = 2;
	localparam int LEN_BIT = 1;
	// Field encodings
	localparam logic RW_READ = 1'h1;
	localparam logic LEN_TWO = 1'h1;
	// Register addresses
	localparam logic [3:0] ADDR_DIR = 4'hA;
	localparam logic [3:0] ADDR_LATCH = 4'hB;
	// Reset values; a direction bit of one makes an output
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic PD_RESET = 1'h1;
	// Host register map
	localparam logic [2:0] H_CMD = 3'h0;
	localparam logic [2:0] H_DATA = 3'h1;
	localparam logic [2:0] H_STATUS = 3'h2;
	localparam logic [2:0] H_RDATA = 3'h3;
	localparam logic [2:0] H_CTRL = 3'h4;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCLK_PERIOD_NS = 400;
	localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ### ctrl_port_if.sv
// Purpose: Pins between host and control port, with shared-line option.
// Assumes: Undriven line floats high.
// Notes: SHARED models the data lines tied into one line.
`timescale 1ns/1ns
interface ctrl_port_if #(parameter bit SHARED = 1'b0) ();
	logic ctrl_shift_clock; // Control clock from host
	logic cs_n; // Chip select, active low
	logic host_data; // Host data drive
	logic host_oe; // Host drive enable
	logic dev_data; // Device data drive
	logic dev_oe; // Device drive enable
	logic hard_reset_in; // Master reset, active high
	logic ctrl_bidir_line; // Resolved shared wire
	logic ctrl_serial_in; // What the device sees
	logic ctrl_serial_out; // What the host sees
	// Wire resolution with pull-up
	assign ctrl_bidir_line = dev_oe ? dev_data : (host_oe ? host_data : 1'b1);
	assign ctrl_serial_in = SHARED ? ctrl_bidir_line : host_data;
	assign ctrl_serial_out = SHARED ? ctrl_bidir_line : (dev_oe ? dev_data : 1'b1);
	modport device (input ctrl_shift_clock, input cs_n, input ctrl_serial_in,
		input hard_reset_in, output dev_data, output dev_oe);
	modport host (output ctrl_shift_clock, output cs_n, output host_data,
		output host_oe, output hard_reset_in, input ctrl_serial_out);
endinterface

// ### ctrl_port_device.sv
// Purpose: Device end of the serial control port with interface latches.
// Assumes: Control clock far slower than clk_i (at least 8 clk per period).
// Notes: All port pins are oversampled; control clock is no clock domain here.
`timescale 1ns/1ns
module ctrl_port_device #(
	parameter int LATCH_W = ctrl_port_pkg::LATCH_W
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	ctrl_port_if.device port,
	input wire logic [LATCH_W-1:0] latch_in_i,
	output logic [LATCH_W-1:0] latch_out_o,
	output logic [LATCH_W-1:0] latch_oe_o,
	output logic powered_down_o,
	output logic wr_stb_o,
	output logic [3:0] wr_addr_o,
	output logic [7:0] wr_data_o
);
	typedef enum logic [1:0] {
		ST_BYTE1 = 2'b00,
		ST_WR2 = 2'b01,
		ST_RD2 = 2'b10
	} state_t;

	// Synchroniser chains; first stage feeds only the second
	logic sclk_m, sclk_s, sclk_d;
	logic cs_m, cs_s;
	logic din_m, din_s, din_d; // Third stage lines up with sclk_d
	logic hr_m, hr_s;
	logic [LATCH_W-1:0] lat_m, lat_s;
	logic rst; // Combined reset

	// Port state
	state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg; // Incoming bits
	logic [7:0] byte1, next_byte1; // Current instruction
	logic [7:0] out_sh, next_out_sh; // Readback bits
	logic dout, next_dout;
	logic doe, next_doe;
	logic [7:0] latch_direction_reg, next_ldr; // latch_direction_reg
	logic [7:0] latch_data_reg, next_ilr; // latch_data_reg
	logic pd, next_pd;
	logic wr_stb, next_wr_stb;
	logic [3:0] wr_addr, next_wr_addr;
	logic [7:0] wr_data, next_wr_data;
	logic [7:0] regs [16]; // Other programmable registers
	logic mem_we; // Array write enable
	logic [7:0] full; // Byte incl. current bit
	logic [7:0] captured; // Latch data after input capture
	logic [7:0] rd_val; // Value returned on read
	logic fall; // Falling control clock edge
	logic sel; // Select low, synchronised

	// oversample all pins with two flops, a third on clock and data
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{sclk_m, sclk_s, sclk_d} <= 3'h0;
			{cs_m, cs_s} <= 2'h3;
			{din_m, din_s, din_d} <= 3'h7;
			{hr_m, hr_s} <= 2'h0;
			lat_m <= '0;
			lat_s <= '0;
		end else begin
			sclk_m <= port.ctrl_shift_clock;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			cs_m <= port.cs_n;
			cs_s <= cs_m;
			din_m <= port.ctrl_serial_in;
			din_s <= din_m;
			din_d <= din_s;
			hr_m <= port.hard_reset_in;
			hr_s <= hr_m;
			lat_m <= latch_in_i;
			lat_s <= lat_m;
		end
	end

	// master reset acts like system reset; pulses under one clock may be missed
	assign rst = sys_rst_i | hr_s;
	assign fall = sclk_d & ~sclk_s;
	assign sel = ~cs_s;
	// sample data held from before the edge
	assign full = {shreg[6:0], din_d};
	// inputs refresh, outputs keep written value
	assign captured = (latch_data_reg & latch_direction_reg) | ({{(8 - LATCH_W){1'b0}}, lat_s} & ~latch_direction_reg);

	// Address field bounds, declared before any use
	localparam int ADDR_HI_C = ctrl_port_pkg::ADDR_HI;
	localparam int ADDR_LO_C = ctrl_port_pkg::ADDR_LO;

	// Readback source for the addressed register
	always_comb begin
		if (full[ADDR_HI_C:ADDR_LO_C] == ctrl_port_pkg::ADDR_DIR) begin
			rd_val = latch_direction_reg;
		end else if (full[ADDR_HI_C:ADDR_LO_C] == ctrl_port_pkg::ADDR_LATCH) begin
			rd_val = captured;
		end else begin
			rd_val = regs[full[ADDR_HI_C:ADDR_LO_C]];
		end
	end

	// Next-state for the serial sequencer and registers
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_byte1 = byte1;
		next_out_sh = out_sh;
		next_dout = dout;
		next_doe = doe;
		next_ldr = latch_direction_reg;
		next_ilr = latch_data_reg;
		next_pd = pd;
		next_wr_stb = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		mem_we = 1'b0;
		if (!sel) begin
			// select high aborts any byte and releases the line
			next_state = ST_BYTE1;
			next_bit_cnt = 4'h0;
			next_doe = 1'b0;
		end else if (fall) begin
			// bits move only on edges inside select
			next_shreg = full;
			next_bit_cnt = bit_cnt + 4'h1;
			if (state == ST_RD2) begin
				// next readback bit after host sampled
				next_dout = out_sh[7];
				next_out_sh = {out_sh[6:0], 1'b0};
			end
			if (bit_cnt == ctrl_port_pkg::BYTE_LAST) begin
				next_bit_cnt = 4'h0;
				case (state)
					ST_BYTE1: begin
						next_byte1 = full;
						next_pd = full[ctrl_port_pkg::P_BIT];
						// sense input pins on each instruction
						next_ilr = captured;
						if (full[ctrl_port_pkg::LEN_BIT] != ctrl_port_pkg::LEN_TWO) begin
							next_state = ST_BYTE1;
						end else if (full[ctrl_port_pkg::RW_BIT] == ctrl_port_pkg::RW_READ) begin
							// read turns the line to drive
							next_state = ST_RD2;
							next_dout = rd_val[7];
							next_out_sh = {rd_val[6:0], 1'b0};
							next_doe = 1'b1;
						end else begin
							next_state = ST_WR2;
						end
					end
					ST_WR2: begin
						// load on eighth edge of second byte
						next_state = ST_BYTE1;
						next_wr_stb = 1'b1;
						next_wr_addr = byte1[ADDR_HI_C:ADDR_LO_C];
						next_wr_data = full;
						mem_we = 1'b1;
						if (byte1[ADDR_HI_C:ADDR_LO_C] == ctrl_port_pkg::ADDR_DIR) begin
							next_ldr = full;
						end else if (byte1[ADDR_HI_C:ADDR_LO_C] == ctrl_port_pkg::ADDR_LATCH) begin
							next_ilr = full;
						end
					end
					ST_RD2: begin
						// drive ends with the data byte
						next_state = ST_BYTE1;
						next_doe = 1'b0;
					end
					default: begin
						next_state = ST_BYTE1;
					end
				endcase
			end
		end
	end

	// Register the sequencer
	always_ff @(posedge clk_i) begin
		if (rst) begin
			state <= ST_BYTE1;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte1 <= 8'h00;
			out_sh <= 8'h00;
			dout <= 1'b1;
			doe <= 1'b0;
			// all latch pins inputs after reset
			latch_direction_reg <= ctrl_port_pkg::DIR_RESET;
			latch_data_reg <= ctrl_port_pkg::LATCH_RESET;
			pd <= ctrl_port_pkg::PD_RESET;
			wr_stb <= 1'b0;
			wr_addr <= 4'h0;
			wr_data <= 8'h00;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			byte1 <= next_byte1;
			out_sh <= next_out_sh;
			dout <= next_dout;
			doe <= next_doe;
			latch_direction_reg <= next_ldr;
			latch_data_reg <= next_ilr;
			pd <= next_pd;
			wr_stb <= next_wr_stb;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
		end
	end

	// general registers back to initial state on reset
	always_ff @(posedge clk_i) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= ctrl_port_pkg::REG_RESET;
			end
		end else if (mem_we) begin
			regs[byte1[ADDR_HI_C:ADDR_LO_C]] <= next_wr_data;
		end
	end

	assign latch_oe_o = latch_direction_reg[LATCH_W-1:0];
	// output pins carry written latch data
	assign latch_out_o = latch_data_reg[LATCH_W-1:0];
	// same drive serves separate or tied lines
	assign port.dev_data = dout;
	assign port.dev_oe = doe;
	assign powered_down_o = pd;
	assign wr_stb_o = wr_stb;
	assign wr_addr_o = wr_addr;
	assign wr_data_o = wr_data;
endmodule

// ### ctrl_port_host.sv
// Purpose: Host end that runs one- and two-byte control instructions.
// Assumes: Software uses the plain register port below.
// Notes: Control clock made from clk_i by a divider.
`timescale 1ns/1ns
module ctrl_port_host #(
	parameter int HALF = ctrl_port_pkg::HALF_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	ctrl_port_if.host port,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SHIFT = 2'b01,
		H_END = 2'b10
	} hstate_t;

	hstate_t state, next_state;
	logic [7:0] data_reg, next_data_reg; // Second byte to send
	logic [7:0] rx, next_rx; // Readback byte
	logic hrst, next_hrst; // Master reset drive
	logic [15:0] tx, next_tx; // Outgoing bits, MSB first
	logic [4:0] idx, next_idx; // Falling edges done
	logic [4:0] last, next_last; // Index of final edge
	logic rd_op, next_rd_op; // Instruction is a two-byte read
	logic [7:0] div, next_div; // Half-period counter
	logic sclk, next_sclk;
	logic cs_n, next_cs_n;
	logic hd, next_hd; // Host data drive
	logic hoe, next_hoe;
	logic [7:0] rdata, next_rdata;
	logic so_m, so_s; // Synchroniser for device data
	logic half_done;

	// Two-flop sampling of the device output
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			so_m <= 1'b1;
			so_s <= 1'b1;
		end else begin
			so_m <= port.ctrl_serial_out;
			so_s <= so_m;
		end
	end

	assign half_done = (div == 8'(HALF - 1));

	// Next-state for sequencer and software registers
	always_comb begin
		next_state = state;
		next_data_reg = data_reg;
		next_rx = rx;
		next_hrst = hrst;
		next_tx = tx;
		next_idx = idx;
		next_last = last;
		next_rd_op = rd_op;
		next_div = div;
		next_sclk = sclk;
		next_cs_n = cs_n;
		next_hd = hd;
		next_hoe = hoe;
		next_rdata = 8'h00;
		// Software writes; a command while busy is dropped
		if (wr_i) begin
			if (addr_i == ctrl_port_pkg::H_DATA) begin
				next_data_reg = wdata_i;
			end else if (addr_i == ctrl_port_pkg::H_CTRL) begin
				// reset stays low unless software raises it
				next_hrst = wdata_i[0];
			end
		end
		// Software reads answer one cycle later
		if (rd_i) begin
			if (addr_i == ctrl_port_pkg::H_DATA) begin
				next_rdata = data_reg;
			end else if (addr_i == ctrl_port_pkg::H_STATUS) begin
				next_rdata = {7'h00, state != H_IDLE};
			end else if (addr_i == ctrl_port_pkg::H_RDATA) begin
				next_rdata = rx;
			end else if (addr_i == ctrl_port_pkg::H_CTRL) begin
				next_rdata = {7'h00, hrst};
			end
		end
		case (state)
			H_IDLE: begin
				if (wr_i && addr_i == ctrl_port_pkg::H_CMD) begin
					// select low before any clock pulse
					// Start: select low, first bit set up while clock low
					next_state = H_SHIFT;
					next_tx = {wdata_i, data_reg};
					next_idx = 5'h00;
					next_last = (wdata_i[ctrl_port_pkg::LEN_BIT] == ctrl_port_pkg::LEN_TWO) ?
						5'h0F : 5'h07;
					next_rd_op = (wdata_i[ctrl_port_pkg::LEN_BIT] == ctrl_port_pkg::LEN_TWO) &&
						(wdata_i[ctrl_port_pkg::RW_BIT] == ctrl_port_pkg::RW_READ);
					next_div = 8'h00;
					next_cs_n = 1'b0;
					next_hd = wdata_i[7];
					next_hoe = 1'b1;
				end
			end
			H_SHIFT: begin
				next_div = div + 8'h01;
				if (half_done) begin
					next_div = 8'h00;
					next_sclk = ~sclk;
					if (sclk) begin
						// eight falls per byte, data moves here
						// Falling edge: device samples; host takes readback
						next_idx = idx + 5'h01;
						next_tx = {tx[14:0], 1'b0};
						next_hd = tx[14];
						if (rd_op && idx >= 5'h08) begin
							next_rx = {rx[6:0], so_s};
						end
						if (rd_op && idx == 5'h07) begin
							// let go before the device drives
							// Hand the shared line to the device
							next_hoe = 1'b0;
						end
						if (idx == last) begin
							next_state = H_END;
						end
					end
				end
			end
			H_END: begin
				// select low across both bytes until here
				// Hold select a half period so the last edge is seen
				next_div = div + 8'h01;
				if (half_done) begin
					next_div = 8'h00;
					next_cs_n = 1'b1;
					next_hoe = 1'b0;
					next_state = H_IDLE;
				end
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
	end

	// Register the host state
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= H_IDLE;
			data_reg <= 8'h00;
			rx <= 8'h00;
			hrst <= 1'b0;
			tx <= 16'h0000;
			idx <= 5'h00;
			last <= 5'h00;
			rd_op <= 1'b0;
			div <= 8'h00;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			hd <= 1'b1;
			hoe <= 1'b0;
			rdata <= 8'h00;
		end else begin
			state <= next_state;
			data_reg <= next_data_reg;
			rx <= next_rx;
			hrst <= next_hrst;
			tx <= next_tx;
			idx <= next_idx;
			last <= next_last;
			rd_op <= next_rd_op;
			div <= next_div;
			sclk <= next_sclk;
			cs_n <= next_cs_n;
			hd <= next_hd;
			hoe <= next_hoe;
			rdata <= next_rdata;
		end
	end

	assign port.ctrl_shift_clock = sclk;
	assign port.cs_n = cs_n;
	assign port.host_data = hd;
	assign port.host_oe = hoe;
	assign port.hard_reset_in = hrst;
	assign rdata_o = rdata;
endmodule

// ### ctrl_port_monitor.sv
// Purpose: Protocol checks on the control port wires.
// Assumes: Host half period of four clocks.
// Notes: Sees interface signals only; both ends are design code.
`timescale 1ns/1ns
module ctrl_port_monitor (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ctrl_shift_clock,
	input wire logic cs_n,
	input wire logic host_oe,
	input wire logic dev_oe,
	input wire logic ctrl_bidir_line
);
	logic sclk_q; // Clock level last cycle
	logic next_sclk_q;
	logic [4:0] falls; // Falling edges in this frame
	logic [4:0] next_falls;
	// Count falls; select high clears the count
	always_comb begin
		next_sclk_q = ctrl_shift_clock;
		next_falls = falls;
		if (cs_n)
			next_falls = 5'h00;
		else if (sclk_q && !ctrl_shift_clock)
			next_falls = falls + 5'h01;
	end
	// Registers only
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sclk_q <= 1'b0;
			falls <= 5'h00;
		end else begin
			sclk_q <= next_sclk_q;
			falls <= next_falls;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_cs_clk_idle: assert property (cs_n |-> !ctrl_shift_clock)
		else $error("control clock moved with select high");
	// Repetition is written out, so it holds for a half period of four only
	a_clk_high_len: assert property ($rose(ctrl_shift_clock) |->
		ctrl_shift_clock [*4] ##1 !ctrl_shift_clock)
		else $error("control clock high time wrong");
	a_frame_bytes: assert property ($rose(cs_n) |-> falls == 5'h08 || falls == 5'h10)
		else $error("frame not one or two whole bytes");
	a_line_stable_high: assert property (ctrl_shift_clock && $past(ctrl_shift_clock)
		|-> $stable(ctrl_bidir_line))
		else $error("data line moved while clock high");
	a_no_contention: assert property (!(dev_oe && host_oe))
		else $error("both ends drive the shared line");
	a_read_turnaround: assert property ($fell(host_oe) && !cs_n |-> ##[1:6] dev_oe)
		else $error("device did not take the line");
	a_drive_after_byte: assert property ($rose(dev_oe) |->
		falls == 5'h08 && $past(host_oe, 5))
		else $error("device drove outside a read byte");
	a_release_idle: assert property (cs_n [*6] |-> !dev_oe)
		else $error("device drives with select high");
endmodule

// ### tb_serial_control_port_latches.sv
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Shared data line, host half period of four clocks.
// Notes: Drivers queue expectations; a monitor process compares.
`timescale 1ns/1ns
module tb_serial_control_port_latches;
	logic clk_i = 1'b0; // System clock
	logic sys_rst_i = 1'b1; // Sync reset
	logic [2:0] addr_i = 3'h0; // Host bus address
	logic [7:0] wdata_i = 8'h00; // Host write data
	logic wr_i = 1'b0; // Write strobe
	logic rd_i = 1'b0; // Read strobe
	logic rd_q = 1'b0; // Read strobe of last cycle
	logic [7:0] rdata_o;
	logic [5:0] latch_in_i = 6'h00; // Pin levels seen by device
	logic [5:0] latch_out_o;
	logic [5:0] latch_oe_o;
	logic powered_down_o;
	logic wr_stb_o;
	logic [3:0] wr_addr_o;
	logic [7:0] wr_data_o;
	logic [11:0] rq[$]; // Expected read data
	logic [11:0] wq[$]; // Expected register loads
	logic [7:0] dir, val, pins, d, e;
	logic [3:0] ad [3] = '{4'h0, 4'h7, 4'hF}; // Plain registers tried
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #25 clk_i = ~clk_i;
	// Tied data lines: one shared wire
	ctrl_port_if #(.SHARED(1'b1)) bus ();
	ctrl_port_host i_ctrl_port_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(bus),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	ctrl_port_device i_ctrl_port_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(bus),
		.latch_in_i(latch_in_i), .latch_out_o(latch_out_o), .latch_oe_o(latch_oe_o),
		.powered_down_o(powered_down_o), .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o));
	ctrl_port_monitor i_ctrl_port_monitor (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.ctrl_shift_clock(bus.ctrl_shift_clock), .cs_n(bus.cs_n), .host_oe(bus.host_oe),
		.dev_oe(bus.dev_oe), .ctrl_bidir_line(bus.ctrl_bidir_line));
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One-cycle write strobe, then a quiet cycle
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Read strobe; the monitor checks the data a cycle later
	task automatic rd(input logic [2:0] a, input logic [7:0] v);
		rq.push_back({4'h0, v});
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Two-byte instruction byte: power bit, address, read bit
	function automatic logic [7:0] mk(input logic p, input logic [3:0] a, input logic r);
		mk = {p, a, r, 2'b10};
	endfunction
	// Send one instruction and wait for the frame to close
	task automatic instr(input logic [7:0] b1, input logic [7:0] b2);
		int n;
		n = 0;
		if (!b1[2])
			wq.push_back({b1[6:3], b2});
		wr(ctrl_port_pkg::H_DATA, b2);
		wr(ctrl_port_pkg::H_CMD, b1);
		rd(ctrl_port_pkg::H_STATUS, 8'h01);
		while (bus.cs_n !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		// Register load lands one clock before select rises
		repeat (8) @(posedge clk_i);
		rd(ctrl_port_pkg::H_STATUS, 8'h00);
	endtask
	// Compare each result as it appears against the oldest note
	always @(posedge clk_i) begin
		rd_q <= rd_i;
		if (rd_q === 1'b1)
			cmp({4'h0, rdata_o}, rq.pop_front());
		if (wr_stb_o === 1'b1)
			cmp({wr_addr_o, wr_data_o}, wq.pop_front());
	end
	// Hang guard; a full run needs about 1500 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(55698));
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		cmp(12'(latch_oe_o), 12'h000);
		cmp(12'(powered_down_o), 12'h001);
		rd(ctrl_port_pkg::H_CTRL, 8'h00);
		rd(3'h5, 8'h00);
		$display("test reset done");
		// Mix of inputs and outputs on the latch pins
		dir = (8'($urandom) | 8'h01) & 8'hFD;
		instr(mk(1'b1, ctrl_port_pkg::ADDR_DIR, 1'b0), dir);
		cmp(12'(latch_oe_o), 12'(dir[5:0]));
		cmp(12'(powered_down_o), 12'h001);
		val = 8'($urandom);
		instr(mk(1'b0, ctrl_port_pkg::ADDR_LATCH, 1'b0), val);
		cmp(12'(latch_out_o), 12'(val[5:0]));
		cmp(12'(powered_down_o), 12'h000);
		$display("test latch write done");
		// Fresh pin levels are captured on the read instruction
		pins = 8'($urandom);
		latch_in_i <= pins[5:0];
		repeat (4) @(posedge clk_i);
		// Bits without a pin read as inputs at level zero unless set as outputs
		e = {val[7:6] & dir[7:6], (val[5:0] & dir[5:0]) | (pins[5:0] & ~dir[5:0])};
		instr(mk(1'b0, ctrl_port_pkg::ADDR_LATCH, 1'b1), 8'h00);
		rd(ctrl_port_pkg::H_RDATA, e);
		cmp(12'(latch_out_o), 12'(e[5:0]));
		$display("test latch read done");
		foreach (ad[i]) begin
			d = 8'($urandom);
			instr(mk(1'b0, ad[i], 1'b0), d);
			instr(mk(1'b0, ad[i], 1'b1), 8'h00);
			rd(ctrl_port_pkg::H_RDATA, d);
		end
		$display("test registers done");
		// Master reset pulse while idle
		wr(ctrl_port_pkg::H_CTRL, 8'h01);
		repeat (4) @(posedge clk_i);
		wr(ctrl_port_pkg::H_CTRL, 8'h00);
		repeat (4) @(posedge clk_i);
		cmp(12'(latch_oe_o), 12'h000);
		cmp(12'(latch_out_o), 12'h000);
		cmp(12'(powered_down_o), 12'h001);
		instr(mk(1'b0, 4'h7, 1'b1), 8'h00);
		rd(ctrl_port_pkg::H_RDATA, 8'h00);
		$display("test master reset done");
		give_verdict();
	end
endmodule
